// ===== dual_timer_counter.sv
// two timer/counters with an axi4-lite register slave
`include "timer_defs.svh"
// Behaviour
// - in 16-bit cascade low byte overflow bumps high byte; high overflow sets flag
// - setting the run bit keeps the count bytes; counting resumes from them
// - timer source increments once per peripheral cycle of six clocks
// - timer rate is aclk frequency over six
// - counter source samples pin each peripheral cycle; high then low increments
// - edge recognition takes two peripheral cycles, so twelve clocks at most rate
// - timer 0 uses mode bits 3:0 and control bits 4,5
// - gate clear: run bit alone enables; gate set: interrupt pin also controls
// - rollover from all ones to zero sets overflow flag, requesting interrupt
// - mode 0: five-bit modulo-32 prescaler in low byte feeds high byte
// - mode 0: upper three low-byte bits take no part in counting
// - mode 1: high and low cascaded into 16 bits, input bumps low
// - mode 2: low counts; overflow sets flag and reloads low from high
// - overflow flag clears when its interrupt is serviced; here software clears it by writing its bit to the ack register
// - mode 2: high byte writes accepted anytime, used at next reload
// - mode 3: timer 0 low byte is an 8-bit timer with timer 0 controls
// - mode 3: timer 0 high byte counts cycles using timer 1 run and flag
// - mode bits: 00 prescaled 13-bit, 01 16-bit, 10 reload, 11 fourth mode
// - gate set: count only while run set and interrupt pin high
// - timer 1 in fourth mode halts and keeps its count
module dual_timer_counter
  import timer_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        count_pin0,
  input  wire logic        count_pin1,
  input  wire logic        ext_interrupt_pin0,
  input  wire logic        ext_interrupt_pin1,
  output logic             overflow_flag_timer0,
  output logic             overflow_flag_timer1
);
  // one counting step for modes 0 to 2; fourth mode handled by caller
  function automatic tstep_s step(input logic [1:0] m, input logic inc,
                                  input logic [7:0] lo, input logic [7:0] hi);
    tstep_s s;
    s = '{low: lo, high: hi, ovf: 1'b0};
    unique case (tmode_e'(m))
      mode_pre13: begin
        s.low[4:0] = lo[4:0] + 5'(inc);
        if (inc && lo[4:0] == 5'h1F) begin
          s.high = hi + 8'h01;
          s.ovf  = (hi == 8'hFF);
        end
      end
      mode_cnt16: begin
        {s.high, s.low} = {hi, lo} + 16'(inc);
        s.ovf = inc && ({hi, lo} == 16'hFFFF);
      end
      mode_reload8: begin
        s.low = (inc && lo == 8'hFF) ? hi : lo + 8'(inc);
        s.ovf = inc && (lo == 8'hFF);
      end
      mode_fourth: s = s;
    endcase
    return s;
  endfunction : step

  logic [7:0] ctrl_r, mode_r, t0lo_r, t0hi_r, t1lo_r, t1hi_r;
  logic [7:0] ctrl_nxt, t0lo_nxt, t0hi_nxt, t1lo_nxt, t1hi_nxt;
  logic [2:0] div_r;
  logic [3:0] s1_r, s2_r, s3_r, filt_r, prev_r;
  logic [7:0] awaddr_r, araddr_r, wdata_r;
  logic        aw_got_r, w_got_r;
  // pins: bit0 count0, bit1 count1, bit2 irq pin0, bit3 irq pin1
  wire [3:0] pins = {ext_interrupt_pin1, ext_interrupt_pin0, count_pin1, count_pin0};
  // a level is accepted only once the second and third stages agree
  wire [3:0] filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
  wire tick = (div_r == `PER_DIV - 3'h1);
  wire edge0 = tick && prev_r[0] && !filt_r[0];
  wire edge1 = tick && prev_r[1] && !filt_r[1];
  wire [1:0] m0    = mode_r[1:0];
  wire [1:0] m1    = mode_r[5:4];
  wire       split = (tmode_e'(m0) == mode_fourth);
  wire       tr0   = ctrl_r[`TR0_BIT];
  wire       tr1   = ctrl_r[`TR1_BIT];

  wire run0 = tr0 && (!mode_r[`GATE_ENABLE_TIMER0_BIT] || filt_r[2]);
  // timer 1 own controls; released from run bit while timer 0 is split
  wire run1 = (split || tr1) && (!mode_r[`GATE1_BIT] || filt_r[3]);
  // timer source steps once per tick; counter source steps on a recognised edge, which falls on a tick
  wire inc0 = run0 && (mode_r[`CT0_BIT] ? edge0 : tick);
  wire inc1 = run1 && (mode_r[`CT1_BIT] ? edge1 : tick);

  wire    [7:0] lo0_sp = t0lo_r + 8'(inc0);
  wire          ovf_lo = inc0 && (t0lo_r == 8'hFF);
  // high byte always times, run by timer 1 run bit
  wire          inc_hi = tr1 && tick;
  wire    [7:0] hi0_sp = t0hi_r + 8'(inc_hi);
  wire          ovf_hi = inc_hi && (t0hi_r == 8'hFF);
  tstep_s st0, st1;
  assign st0 = step(m0, inc0, t0lo_r, t0hi_r);
  assign st1 = step(m1, inc1, t1lo_r, t1hi_r);

  // split low byte uses timer 0 controls
  wire set_tf0 = split ? ovf_lo : st0.ovf;
  wire set_tf1 = split ? ovf_hi : st1.ovf;

  // write decode: a write happens once address and data are both held
  wire do_wr   = aw_got_r && w_got_r && !bvalid;
  wire wr_ctrl = do_wr && awaddr_r == `CTRL_OFF;
  wire wr_mode = do_wr && awaddr_r == `MODE_OFF;
  wire wr_t0lo = do_wr && awaddr_r == `T0LO_OFF;
  wire wr_t0hi = do_wr && awaddr_r == `T0HI_OFF;
  wire wr_t1lo = do_wr && awaddr_r == `T1LO_OFF;
  wire wr_t1hi = do_wr && awaddr_r == `T1HI_OFF;
  wire wr_ack  = do_wr && awaddr_r == `ACK_OFF;
  wire wr_hit  = wr_ctrl | wr_mode | wr_t0lo | wr_t0hi | wr_t1lo | wr_t1hi | wr_ack;
  wire [7:0] wb = wdata_r;
  wire ack0 = wr_ack && wb[0];
  wire ack1 = wr_ack && wb[1];
  // counts only move by step or write, never cleared by run
  assign t0lo_nxt = wr_t0lo ? wb : (split ? lo0_sp : st0.low);
  assign t0hi_nxt = wr_t0hi ? wb : (split ? hi0_sp : st0.high);
  assign t1lo_nxt = wr_t1lo ? wb : st1.low;
  assign t1hi_nxt = wr_t1hi ? wb : st1.high;

  // flags: a hardware set wins over software clear in the same cycle
  always_comb begin
    ctrl_nxt = wr_ctrl ? wb : ctrl_r;
    if (ack0)
      ctrl_nxt[`TF0_BIT] = 1'b0;
    if (ack1)
      ctrl_nxt[`TF1_BIT] = 1'b0;
    if (set_tf0)
      ctrl_nxt[`TF0_BIT] = 1'b1;
    if (set_tf1)
      ctrl_nxt[`TF1_BIT] = 1'b1;
  end

  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    unique case (araddr_r)
      `CTRL_OFF: rd_byte = ctrl_r;
      `MODE_OFF: rd_byte = mode_r;
      `T0LO_OFF: rd_byte = t0lo_r;
      `T0HI_OFF: rd_byte = t0hi_r;
      `T1LO_OFF: rd_byte = t1lo_r;
      `T1HI_OFF: rd_byte = t1hi_r;
      `ACK_OFF:  rd_byte = 8'h00;
      default:   rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r  <= 3'h0;
      s1_r   <= 4'h0;
      s2_r   <= 4'h0;
      s3_r   <= 4'h0;
      filt_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      div_r  <= tick ? 3'h0 : div_r + 3'h1;
      s1_r   <= pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
      if (tick)
        prev_r <= filt_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CTRL_RST;
      mode_r <= `MODE_RST;
      t0lo_r <= `CNT_RST;
      t0hi_r <= `CNT_RST;
      t1lo_r <= `CNT_RST;
      t1hi_r <= `CNT_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      // mode changes take effect at once; stopping first is on software
      if (wr_mode)
        mode_r <= wb;
      t0lo_r <= t0lo_nxt;
      t0hi_r <= t0hi_nxt;
      t1lo_r <= t1lo_nxt;
      t1hi_r <= t1hi_nxt;
    end
  end

  // axi4-lite slave: address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 8'h00;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        // only byte lane 0 carries register bits
        wdata_r <= wstrb[0] ? wdata[7:0] : 8'h00;
      end
      if (do_wr) begin
        bvalid   <= 1'b1;
        bresp    <= wr_hit ? `RESP_OK : `RESP_ERR;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= !aw_got_r && !(awvalid && awready) && !bvalid;
      wready  <= !w_got_r && !(wvalid && wready) && !bvalid;
    end
  end

  logic rd_pend_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready   <= 1'b0;
      rd_pend_r <= 1'b0;
      araddr_r  <= 8'h00;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= `RESP_OK;
    end else begin
      arready <= !rd_pend_r && !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        araddr_r  <= araddr;
        rd_pend_r <= 1'b1;
      end
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        rvalid    <= 1'b1;
        rdata     <= {24'h00_0000, rd_byte};
        rresp     <= rd_hit ? `RESP_OK : `RESP_ERR;
      end else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_timer0 <= 1'b0;
      overflow_flag_timer1 <= 1'b0;
    end else begin
      overflow_flag_timer0 <= ctrl_nxt[`TF0_BIT];
      overflow_flag_timer1 <= ctrl_nxt[`TF1_BIT];
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire nw0 = !wr_t0lo && !wr_t0hi && !wr_ctrl;
  wire nw1 = !wr_t1lo && !wr_t1hi;
  a_tick_period: assert property (tick |=> !tick [*5] ##1 tick)
    else $error("peripheral cycle is not six clocks");
  a_run_holds: assert property (!run0 && !split && nw0 |=>
    $stable(t0lo_r) && $stable(t0hi_r))
    else $error("timer 0 moved while stopped");
  a_cascade_ovf: assert property (m0 == 2'b01 && inc0 &&
    {t0hi_r, t0lo_r} == 16'hFFFF && nw0 |=> ctrl_r[`TF0_BIT] && t0hi_r == 8'h00)
    else $error("16-bit rollover missed flag");
  a_timer_rate: assert property (m0 == 2'b01 && run0 && !mode_r[`CT0_BIT] && tick &&
    nw0 |=> {t0hi_r, t0lo_r} == $past({t0hi_r, t0lo_r}) + 16'h0001)
    else $error("timer did not step on tick");
  a_edge_count: assert property (mode_r[`CT0_BIT] && !tick |-> !inc0)
    else $error("counter stepped off a sample point");
  a_prescale_carry: assert property (m0 == 2'b00 && inc0 &&
    t0lo_r[4:0] == 5'h1F && nw0 |=> t0hi_r == $past(t0hi_r) + 8'h01)
    else $error("prescaler carry lost");
  a_reload_low: assert property (m0 == 2'b10 && inc0 && t0lo_r == 8'hFF &&
    nw0 |=> t0lo_r == $past(t0hi_r) && ctrl_r[`TF0_BIT])
    else $error("auto-reload wrong");
  a_split_high: assert property (split && tr1 && tick && nw0 |=>
    t0hi_r == $past(t0hi_r) + 8'h01)
    else $error("split high byte did not time");
  a_t1_halt: assert property (m1 == 2'b11 && nw1 |=>
    $stable(t1lo_r) && $stable(t1hi_r))
    else $error("timer 1 moved in halt mode");
  a_set_wins: assert property (set_tf0 && ack0 |=> ctrl_r[`TF0_BIT])
    else $error("flag set lost to clear");
  a_gate_stop: assert property (tr0 && mode_r[`GATE_ENABLE_TIMER0_BIT] && !filt_r[2] |-> !inc0)
    else $error("gated timer counted with pin low");
  c_ovf16: cover property (m0 == 2'b01 && set_tf0);
  c_reload: cover property (m0 == 2'b10 && set_tf0);
  c_split: cover property (split && ovf_hi);
  c_edge: cover property (mode_r[`CT1_BIT] && inc1);
endmodule : dual_timer_counter

// ===== dual_timer_counter_tb_top.sv
// self-checking bench for the dual timer block
`include "timer_defs.svh"
module dual_timer_counter_tb_top;
  import timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pin0, pin1, gate_enable_timer0 = 1, gate1 = 1, ovf0, ovf1;
  int fails = 0, n_tests = 0, cyc = 0, t1, t2;
  logic [31:0] d;
  logic [1:0] r;
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  pin_source src0 (.aclk(aclk), .pin(pin0));
  pin_source src1 (.aclk(aclk), .pin(pin1));
  dual_timer_counter uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .count_pin0(pin0), .count_pin1(pin1), .ext_interrupt_pin0(gate_enable_timer0),
    .ext_interrupt_pin1(gate1), .overflow_flag_timer0(ovf0), .overflow_flag_timer1(ovf1));
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic timeout;
    fails++;
    give_verdict();
  endtask : timeout
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int k;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1; wdata <= {24'h0000_00, v}; wstrb <= 4'hF; wvalid <= 1;
    bready <= 1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    if (k == 100) timeout();
    bready <= 0;
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    if (k == 100) timeout();
    rready <= 0;
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic wait_flag(input logic [1:0] which);
    int k;
    for (k = 0; k < 1000; k++) begin
      @(posedge aclk);
      if ((which[0] && ovf0) || (which[1] && ovf1)) break;
    end
    if (k == 1000) timeout();
  endtask : wait_flag
  task automatic set_timer(input logic [7:0] lo_a, input logic [7:0] m, input logic [7:0] lo,
                           input logic [7:0] hi);
    // stop before presetting counts or mode
    wr(`CTRL_OFF, 8'h00);
    wr(`MODE_OFF, m);
    wr(lo_a, lo);
    wr(lo_a + 8'h04, hi);
  endtask : set_timer
  task automatic reset_and_map;
    rd(`CTRL_OFF); chk(d, {24'h0000_00, `CTRL_RST});
    chk(r, `RESP_OK);
    rd(`MODE_OFF); chk(d, {24'h0000_00, `MODE_RST});
    rd(`T0LO_OFF); chk(d, {24'h0000_00, `CNT_RST});
    rd(8'h1C); chk(d, 32'h0000_0000);
    chk(r, `RESP_ERR);
    wr(8'h1C, 8'h00); chk(r, `RESP_ERR);
  endtask : reset_and_map
  task automatic cascade16;
    set_timer(`T0LO_OFF, 8'h01, 8'hFF, 8'hFF);
    wr(`CTRL_OFF, 8'h10); chk(r, `RESP_OK);
    wait_flag(2'b01);
    rd(`CTRL_OFF); chk(d, 32'h0000_0030);
    wr(`ACK_OFF, 8'h01);
    chk(ovf0, 1'b0);
    rd(`CTRL_OFF); chk(d, 32'h0000_0010);
    wr(`CTRL_OFF, 8'h00);
    rd(`T0HI_OFF); chk(d, 32'h0000_0000);
  endtask : cascade16
  task automatic prescale13;
    set_timer(`T0LO_OFF, 8'h00, 8'hFF, 8'h00);
    wr(`CTRL_OFF, 8'h10);
    repeat (12) @(posedge aclk);
    wr(`CTRL_OFF, 8'h00);
    rd(`T0HI_OFF); chk(d, 32'h0000_0001);
    rd(`T0LO_OFF); chk(d[7:5], 3'b111);
  endtask : prescale13
  // reload period of sixteen ticks is 96 clocks, then thirty-two ticks after the new reload
  task automatic reload8;
    set_timer(`T0LO_OFF, 8'h02, 8'hF0, 8'hF0);
    wr(`CTRL_OFF, 8'h10);
    wait_flag(2'b01);
    t1 = cyc;
    wr(`ACK_OFF, 8'h01);
    wr(`T0HI_OFF, 8'hE0);
    wait_flag(2'b01);
    t2 = cyc;
    chk(t2 - t1, 96);
    wr(`ACK_OFF, 8'h01);
    wait_flag(2'b01);
    chk(cyc - t2, 192);
    wr(`CTRL_OFF, 8'h00);
    rd(`T0HI_OFF); chk(d, 32'h0000_00E0);
    wr(`ACK_OFF, 8'h01);
  endtask : reload8
  task automatic gating;
    set_timer(`T0LO_OFF, 8'h09, 8'h00, 8'h00);
    @(posedge aclk) gate_enable_timer0 <= 0;
    // let the low gate level pass the pin synchroniser before running
    repeat (6) @(posedge aclk);
    wr(`CTRL_OFF, 8'h10);
    repeat (60) @(posedge aclk);
    rd(`T0LO_OFF); chk(d, 32'h0000_0000);
    @(posedge aclk) gate_enable_timer0 <= 1;
    repeat (60) @(posedge aclk);
    wr(`CTRL_OFF, 8'h00);
    rd(`T0LO_OFF); chk(d >= 32'h0000_0009 && d <= 32'h0000_000A, 1'b1);
  endtask : gating
  task automatic count_edges;
    set_timer(`T1LO_OFF, 8'h55, 8'h00, 8'h00);
    wr(`T0LO_OFF, 8'h00);
    wr(`T0HI_OFF, 8'h00);
    wr(`CTRL_OFF, 8'h50);
    src1.pulses(5, 12);
    src1.pulses(4, 6);
    src0.pulses(2, 6);
    repeat (30) @(posedge aclk);
    wr(`CTRL_OFF, 8'h00);
    rd(`T1LO_OFF); chk(d, 32'h0000_0009);
    rd(`T0LO_OFF); chk(d, 32'h0000_0002);
  endtask : count_edges
  task automatic halt1;
    set_timer(`T1LO_OFF, 8'h30, 8'h55, 8'h00);
    wr(`CTRL_OFF, 8'h40);
    repeat (40) @(posedge aclk);
    rd(`T1LO_OFF); chk(d, 32'h0000_0055);
    wr(`CTRL_OFF, 8'h00);
  endtask : halt1
  // split timer 0: high byte wraps eight ticks before the low byte
  task automatic split3;
    set_timer(`T0LO_OFF, 8'h33, 8'hF0, 8'hF8);
    wr(`CTRL_OFF, 8'h50);
    wait_flag(2'b10);
    t1 = cyc;
    chk(ovf0, 1'b0);
    wait_flag(2'b01);
    chk(cyc - t1, 48);
    chk(ovf1, 1'b1);
    wr(`CTRL_OFF, 8'h00);
    rd(`T1LO_OFF); chk(d, 32'h0000_0055);
  endtask : split3
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    reset_and_map();
    cascade16();
    prescale13();
    reload8();
    gating();
    count_edges();
    halt1();
    split3();
    give_verdict();
  end
endmodule : dual_timer_counter_tb_top

// ===== pin_source.sv
// behavioural far-side source for one external count pin
module pin_source (
  input  wire logic aclk,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b1;
  // level hold: each level stays at least one peripheral cycle
  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      @(posedge aclk) pin <= 1'b0;
      repeat (hold) @(posedge aclk);
      pin <= 1'b1;
      repeat (hold) @(posedge aclk);
    end
  endtask : pulses
endmodule : pin_source

// ===== timer_defs.svh
// offsets, bit positions, reset values and timing counts of the timer block
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define CTRL_OFF  8'h00
`define MODE_OFF  8'h04
`define T0LO_OFF  8'h08
`define T0HI_OFF  8'h0C
`define T1LO_OFF  8'h10
`define T1HI_OFF  8'h14
`define ACK_OFF   8'h18
`define TF1_BIT   7
`define TR1_BIT   6
`define TF0_BIT   5
`define TR0_BIT   4
`define GATE_ENABLE_TIMER0_BIT 3
`define CT0_BIT   2
`define GATE1_BIT 7
`define CT1_BIT   6
`define CTRL_RST  8'h00
`define MODE_RST  8'h00
`define CNT_RST   8'h00
`define PER_DIV   3'h6
`define RESP_OK   2'h0
`define RESP_ERR  2'h2
`endif

// ===== timer_pkg.sv
// types shared by the timer block
package timer_pkg;
  typedef enum logic [1:0] {
    mode_pre13, mode_cnt16, mode_reload8, mode_fourth
  } tmode_e;
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf;
  } tstep_s;
endpackage : timer_pkg
